// ===== reset_status_and_startup_control_tb.sv
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module reset_status_and_startup_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rsc_pkg::*;
   typedef struct packed {logic [12:0] ev; logic [15:0] flags;} rsc_row_t;
   localparam logic [31:0] A_RC = {24'h00_0000, OFF_RESET_CTRL};
   localparam logic [31:0] A_IC = {24'h00_0000, OFF_INT_CTRL};
   logic mclk, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize, int_prio, cpu_prio;
   logic master_clear_pin_n, supply_low, regulator_en, pll_en;
   logic [12:0] ev;
   logic core_rst, pc_load, soft_trap;
   logic [23:0] pc_value, cur_pc, int_vec, pc_at_req;
   int n_mismatch, checks, n;
   rsc_row_t rows [6];
   assign hready = hreadyout;

   rsc_top #(.POWERUP_CYC(32'h0000_0032), .REG_SETTLE_CYC(32'h0000_000A),
      .REG_EXTRA_CYC(32'h0000_0008), .OSC_START_CYC(32'h0000_0006),
      .PLL_LOCK_CYC(32'h0000_0005)) u_rsc_top (
      .mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .master_clear_pin_n(master_clear_pin_n),
      .supply_low(supply_low), .regulator_en(regulator_en), .pll_en(pll_en),
      .swr_req(ev[0]), .wdt_timeout(ev[1]), .illegal_opcode(ev[2]),
      .uninit_pointer(ev[3]), .cfg_mismatch(ev[4]), .cfg_parity_err(ev[5]),
      .trap_event(ev[6]), .trap_clear(ev[7]), .stack_overflow(ev[8]),
      .stack_underflow(ev[9]), .sleep_req(ev[10]), .idle_req(ev[11]), .wake_int(ev[12]),
      .int_prio(int_prio), .cpu_prio(cpu_prio), .cur_pc(cur_pc), .int_vec(int_vec),
      .core_rst(core_rst), .pc_load(pc_load), .pc_value(pc_value), .soft_trap(soft_trap)
   );

   rsc_core_model u_rsc_core_model (
      .mclk(mclk), .core_rst(core_rst), .pc_load(pc_load), .pc_value(pc_value),
      .cur_pc(cur_pc)
   );

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Single transfer of size sz; held until hready is seen high
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
         input logic [2:0] sz);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= a;
      hsize <= sz;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic pulse(input logic [12:0] m);
      @(posedge mclk);
      ev <= m;
      #1 pc_at_req = cur_pc;
      @(posedge mclk);
      ev <= 13'h0000;
   endtask

   task automatic wait_load(input int lim);
      n = 0;
      #1;
      while (pc_load !== 1'b1 && n < lim) begin
         @(posedge mclk);
         #1 n++;
      end
      `CHK(n < lim, 1'b1)
   endtask

   task automatic wait_release();
      wait_load(500);
      `CHK(pc_value, PC_RESET)
      `CHK(core_rst, 1'b0)
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      $display("watchdog expired");
      wrap_up();
   end

   initial begin
      n_mismatch = 0;
      checks = 0;
      sys_rst = 1'b1;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = SIZE_WORD;
      {master_clear_pin_n, supply_low, regulator_en, pll_en} = 4'b1000;
      ev = 13'h0000;
      int_prio = 3'h2;
      cpu_prio = 3'h3;
      int_vec = 24'h00_0100;
      rows[0] = {13'h0001, 16'h0040};
      rows[1] = {13'h0002, 16'h0010};
      rows[2] = {13'h0004, 16'h4000};
      rows[3] = {13'h0008, 16'h4000};
      rows[4] = {13'h0010, 16'h0200};
      rows[5] = {13'h0020, 16'h0200};
      repeat (16) @(posedge mclk);
      sys_rst <= 1'b0;
      wait_release();
      `CHK(n >= 56, 1'b1)
      bus(1'b0, A_RC, 32'h0, SIZE_WORD);
      `CHK(rd, 32'h0000_0001)
      `CHK({hresp, hreadyout}, 2'b01)
      $display("test power-on done");
      bus(1'b1, A_RC, 32'h0, 3'h0);
      bus(1'b0, A_RC, 32'h0, SIZE_WORD);
      `CHK(rd, 32'h0000_0001)
      bus(1'b1, 32'h0000_0010, 32'hFFFF_FFFF, SIZE_WORD);
      bus(1'b0, 32'h0000_0010, 32'h0, SIZE_WORD);
      `CHK(rd, 32'h0000_0000)
      bus(1'b1, A_RC, 32'h0000_0100, SIZE_WORD);
      bus(1'b0, A_RC, 32'h0, SIZE_WORD);
      `CHK(rd, 32'h0000_0100)
      $display("test bus done");
      foreach (rows[i]) begin
         bus(1'b1, A_RC, 32'h0, SIZE_WORD);
         pulse(rows[i].ev);
         #1 `CHK(core_rst, 1'b1)
         wait_release();
         bus(1'b0, A_RC, 32'h0, SIZE_WORD);
         `CHK(rd, {16'h0000, rows[i].flags})
         $display("test row %0d done", i);
      end
      pulse(13'h0040);
      pulse(13'h0080);
      pulse(13'h0040);
      #1 `CHK(core_rst, 1'b0)
      pulse(13'h0080);
      pulse(13'h0100);
      #1 `CHK({soft_trap, pc_load, core_rst}, 3'b110)
      `CHK(pc_value, STACK_VEC)
      bus(1'b0, A_IC, 32'h0, SIZE_WORD);
      `CHK(rd, 32'h0000_0004)
      pulse(13'h0200);
      #1 `CHK(core_rst, 1'b1)
      wait_release();
      bus(1'b0, A_RC, 32'h0, SIZE_WORD);
      `CHK(rd, 32'h0000_8200)
      bus(1'b0, A_IC, 32'h0, SIZE_WORD);
      `CHK(rd, 32'h0000_0000)
      $display("test trap done");
      bus(1'b1, A_RC, 32'h0000_0040, SIZE_WORD);
      pulse(13'h0010);
      wait_release();
      bus(1'b0, A_RC, 32'h0, SIZE_WORD);
      `CHK(rd, 32'h0000_0240)
      $display("test mismatch done");
      bus(1'b1, A_RC, 32'h0, SIZE_WORD);
      pulse(13'h0400);
      bus(1'b0, {24'h00_0000, OFF_STATUS}, 32'h0, SIZE_WORD);
      `CHK(rd, 32'h0000_0020)
      pulse(13'h1000);
      wait_load(4);
      `CHK(pc_value, pc_at_req + 24'h00_0002)
      `CHK(core_rst, 1'b0)
      pulse(13'h0400);
      pulse(13'h0002);
      wait_load(4);
      `CHK(pc_value, pc_at_req + 24'h00_0002)
      int_prio <= 3'h5;
      pulse(13'h0800);
      pulse(13'h1000);
      wait_load(4);
      `CHK(pc_value, int_vec)
      bus(1'b0, A_RC, 32'h0, SIZE_WORD);
      `CHK(rd, 32'h0000_003C)
      $display("test wake done");
      bus(1'b1, A_RC, 32'h0, SIZE_WORD);
      supply_low <= 1'b1;
      repeat (8) @(posedge mclk);
      supply_low <= 1'b0;
      #1 `CHK(core_rst, 1'b0)
      @(posedge mclk);
      master_clear_pin_n <= 1'b0;
      repeat (24) @(posedge mclk);
      #1 `CHK(core_rst, 1'b1)
      @(posedge mclk);
      master_clear_pin_n <= 1'b1;
      wait_release();
      bus(1'b0, A_RC, 32'h0, SIZE_WORD);
      `CHK(rd, 32'h0000_0080)
      $display("test pin done");
      bus(1'b1, A_RC, 32'h0, SIZE_WORD);
      regulator_en <= 1'b1;
      pll_en <= 1'b1;
      supply_low <= 1'b1;
      repeat (24) @(posedge mclk);
      #1 `CHK(core_rst, 1'b1)
      @(posedge mclk);
      supply_low <= 1'b0;
      wait_release();
      `CHK(n >= 29 && n < 50, 1'b1)
      bus(1'b0, A_RC, 32'h0, SIZE_WORD);
      `CHK(rd, 32'h0000_0002)
      $display("test brownout done");
      bus(1'b1, A_RC, 32'h0000_FFFF, SIZE_WORD);
      sys_rst <= 1'b1;
      repeat (16) @(posedge mclk);
      sys_rst <= 1'b0;
      bus(1'b0, A_RC, 32'h0, SIZE_WORD);
      `CHK(rd, 32'h0000_0001)
      $display("test second reset done");
      wrap_up();
   end
endmodule
`default_nettype wire

// ===== rsc_core_model.sv
`default_nettype none
module rsc_core_model (
   // Clock and core hold
   input wire logic mclk,
   input wire logic core_rst,
   // Program counter control
   input wire logic pc_load,
   input wire logic [23:0] pc_value,
   // Fetch address
   output logic [23:0] cur_pc
);
   timeunit 1ns;
   timeprecision 1ps;
   // Fetch advances one word a cycle, jumps on load, parks at zero while held
   always_ff @(posedge mclk) begin
      if (core_rst)
         cur_pc <= 24'h00_0000;
      else if (pc_load)
         cur_pc <= pc_value;
      else
         cur_pc <= cur_pc + 24'h00_0002;
   end
endmodule
`default_nettype wire

// ===== rsc_pkg.sv
`default_nettype none
package rsc_pkg;
   // Clock and start-up timing
   localparam logic [31:0] CLK_MHZ = 32'h0000_00FA;
   localparam logic [31:0] MS_TO_US = 32'h0000_03E8;
   localparam logic [31:0] POWERUP_TIMER_INTERVAL_MS = 32'h0000_0040;
   localparam logic [31:0] REGULATOR_SETTLE_INTERVAL_US = 32'h0000_000A;
   localparam logic [31:0] REGULATOR_EXTRA_US = 32'h0000_000A;
   localparam logic [31:0] POWERUP_CYC = POWERUP_TIMER_INTERVAL_MS * MS_TO_US * CLK_MHZ;
   localparam logic [31:0] REG_SETTLE_CYC = REGULATOR_SETTLE_INTERVAL_US * CLK_MHZ;
   localparam logic [31:0] REG_EXTRA_CYC = REGULATOR_EXTRA_US * CLK_MHZ;
   localparam logic [31:0] OSC_START_CYC = 32'h0000_0400;
   localparam logic [31:0] PLL_LOCK_CYC = 32'h0000_0800;
   // Register offsets
   localparam logic [7:0] OFF_RESET_CTRL = 8'h00;
   localparam logic [7:0] OFF_INT_CTRL = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [2:0] SIZE_WORD = 3'h2;
   // Reset control register fields
   localparam int B_POWER_ON = 0;
   localparam int B_BROWNOUT = 1;
   localparam int B_IDLE = 2;
   localparam int B_SLEEP = 3;
   localparam int B_WATCHDOG = 4;
   localparam int B_WAKE_INT = 5;
   localparam int B_SOFTWARE = 6;
   localparam int B_EXTERNAL = 7;
   localparam int B_REG_STANDBY = 8;
   localparam int B_MISMATCH = 9;
   localparam int B_ILLEGAL_OP = 14;
   localparam int B_TRAP_CONFLICT = 15;
   localparam logic [15:0] RESET_CTRL_MASK = 16'hC3FF;
   localparam logic [15:0] RESET_CTRL_RST = 16'h0001;
   // Interrupt control register fields
   localparam int B_STACK_ERR = 2;
   // Program counter values
   localparam logic [23:0] PC_RESET = 24'h00_0000;
   localparam logic [23:0] PC_INC = 24'h00_0002;
   localparam logic [23:0] STACK_VEC = 24'h00_000A;
   typedef enum logic [2:0] {ST_RUN, ST_HOLD, ST_STUP, ST_REGX, ST_OSC, ST_PLL} rsc_state_t;
   typedef enum logic [1:0] {MD_RUN, MD_SLEEP, MD_IDLE} rsc_mode_t;
   typedef enum logic [2:0] {
      CZ_NONE, CZ_BROWNOUT, CZ_EXTERNAL, CZ_MISMATCH, CZ_TRAP, CZ_ILLEGAL, CZ_WATCHDOG,
      CZ_SOFTWARE
   } rsc_cause_t;
   typedef enum logic [1:0] {IX_NONE, IX_RESET_CTRL, IX_INT_CTRL, IX_STATUS} rsc_index_t;
endpackage
`default_nettype wire

// ===== rsc_timer.sv
`default_nettype none
module rsc_timer (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Load
   input wire logic start,
   input wire logic [31:0] load_val,
   // Status
   output logic busy,
   output logic done
);
   typedef struct packed {
      logic [31:0] cnt;
      logic busy;
      logic done;
   } rsc_tmr_t;
   rsc_tmr_t s, n;
   always_comb begin
      n = s;
      n.done = 1'b0;
      if (start) begin
         n.cnt = load_val;
         n.busy = 1'b1;
      end else if (s.busy) begin
         if (s.cnt <= 32'h0000_0001) begin
            n.busy = 1'b0;
            n.done = 1'b1;
         end else begin
            n.cnt = s.cnt - 32'h0000_0001;
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end
   assign busy = s.busy;
   assign done = s.done;
endmodule
`default_nettype wire

// ===== rsc_top.sv
// Operation
// - Interrupt wake resumes at PC+2 if priority not above CPU level, else vector.
// - Illegal opcode or uninitialised pointer use resets and sets its flag.
// - Configuration copy mismatch or parity error resets and sets mismatch flag.
// - Second trap before first is cleared resets and sets trap conflict flag.
// - Stack overflow or underflow raises soft trap to vector 000Ah, no reset.
// - Overflow and underflow share one stack error flag.
// - With regulator on, brown-out always active; supply low holds reset.
// - Any reset other than a configuration mismatch returns registers to defaults, except reset control bits.
// - Wake from power saving changes no register except its wake or watchdog flag.
// - POR/BOR start-up waits power-up time, or settle time with regulator.
// - Power-up timer interval is 64 ms before release.
// - Regulator settle interval is 10 us before release.
// - Regulator standby bit clear adds a further regulator delay.
// - Oscillator start-up and optional PLL lock delays follow before execution.
// - Master clear pin acts as external reset unless brown-out is active.
// - Status flags are active high.
// - Each reset event sets only its own flag.
// - Twelve flags in reset control register, stack error in interrupt control.
// - Sleep and idle flags set on entry to that state.
`default_nettype none
module rsc_top #(
   parameter logic [31:0] POWERUP_CYC = rsc_pkg::POWERUP_CYC,
   parameter logic [31:0] REG_SETTLE_CYC = rsc_pkg::REG_SETTLE_CYC,
   parameter logic [31:0] REG_EXTRA_CYC = rsc_pkg::REG_EXTRA_CYC,
   parameter logic [31:0] OSC_START_CYC = rsc_pkg::OSC_START_CYC,
   parameter logic [31:0] PLL_LOCK_CYC = rsc_pkg::PLL_LOCK_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Pins and supply monitors
   input wire logic master_clear_pin_n,
   input wire logic supply_low,
   input wire logic regulator_en,
   input wire logic pll_en,
   // Core events
   input wire logic swr_req,
   input wire logic wdt_timeout,
   input wire logic illegal_opcode,
   input wire logic uninit_pointer,
   input wire logic cfg_mismatch,
   input wire logic cfg_parity_err,
   input wire logic trap_event,
   input wire logic trap_clear,
   input wire logic stack_overflow,
   input wire logic stack_underflow,
   input wire logic sleep_req,
   input wire logic idle_req,
   input wire logic wake_int,
   input wire logic [2:0] int_prio,
   input wire logic [2:0] cpu_prio,
   input wire logic [23:0] cur_pc,
   input wire logic [23:0] int_vec,
   // Core control
   output logic core_rst,
   output logic pc_load,
   output logic [23:0] pc_value,
   output logic soft_trap
);
   import rsc_pkg::*;

   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      rsc_state_t st;
      rsc_mode_t mode;
      logic por_like;
      logic [15:0] rst_ctrl;
      logic stack_err;
      logic trap_pend;
      logic core_rst;
      logic pc_load;
      logic [23:0] pc_val;
      logic soft_trap;
      logic tm_start;
      logic [31:0] tm_load;
      logic dwr;
      rsc_index_t dsel;
      logic [31:0] hrdata;
      logic hreadyout;
   } rsc_state_s_t;

   rsc_state_s_t s, n;
   rsc_cause_t cause;
   logic tm_done;
   logic tm_fin;
   logic master_clear_pin;
   logic brown;
   logic stk;
   logic stk_go;
   logic wake_go;
   logic rel;
   rsc_index_t aidx;

   function automatic rsc_index_t rsc_decode(input logic [7:0] a);
      if (a == OFF_RESET_CTRL) begin
         return IX_RESET_CTRL;
      end else if (a == OFF_INT_CTRL) begin
         return IX_INT_CTRL;
      end else if (a == OFF_STATUS) begin
         return IX_STATUS;
      end else begin
         return IX_NONE;
      end
   endfunction

   rsc_timer u_timer (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .start(s.tm_start),
      .load_val(s.tm_load),
      .busy(),
      .done(tm_done)
   );

   always_comb begin
      n = s;
      n.s1 = {regulator_en, supply_low, master_clear_pin_n};
      n.s2 = s.s1;
      n.pc_load = 1'b0;
      n.soft_trap = 1'b0;
      n.tm_start = 1'b0;
      n.hreadyout = 1'b1;
      n.dwr = 1'b0;
      cause = CZ_NONE;
      stk_go = 1'b0;
      wake_go = 1'b0;
      rel = 1'b0;
      aidx = IX_NONE;
      master_clear_pin = ~s.s2[0];
      brown = s.s2[2] & s.s2[1];
      stk = stack_overflow | stack_underflow;
      // A done left over from a phase cut short by a reset is ignored
      tm_fin = tm_done & ~s.tm_start;
      // Data phase write; later events in this cycle win over it
      if (s.dwr) begin
         if (s.dsel == IX_RESET_CTRL) begin
            n.rst_ctrl = hwdata[15:0] & RESET_CTRL_MASK;
         end else if (s.dsel == IX_INT_CTRL) begin
            n.stack_err = hwdata[B_STACK_ERR];
         end
      end
      // Address phase
      if (hsel && hready && htrans[1] && hsize == SIZE_WORD) begin
         aidx = rsc_decode(haddr[7:0]);
         n.dwr = hwrite;
         n.dsel = aidx;
         n.hrdata = 32'h0000_0000;
         if (!hwrite) begin
            if (aidx == IX_RESET_CTRL) begin
               n.hrdata = {16'h0000, n.rst_ctrl};
            end else if (aidx == IX_INT_CTRL) begin
               n.hrdata[B_STACK_ERR] = n.stack_err;
            end else if (aidx == IX_STATUS) begin
               n.hrdata[6:0] = {s.mode, s.st, s.trap_pend, s.core_rst};
            end
         end
      end
      // Reset cause, one per cycle
      if (brown) begin
         cause = CZ_BROWNOUT;
      end else if (master_clear_pin) begin
         cause = CZ_EXTERNAL;
      end else if (s.st == ST_RUN) begin
         if (cfg_mismatch || cfg_parity_err) begin
            cause = CZ_MISMATCH;
         end else if (s.trap_pend && (trap_event || stk)) begin
            cause = CZ_TRAP;
         end else if (illegal_opcode || uninit_pointer) begin
            cause = CZ_ILLEGAL;
         end else if (wdt_timeout && s.mode == MD_RUN) begin
            cause = CZ_WATCHDOG;
         end else if (swr_req && s.mode == MD_RUN) begin
            cause = CZ_SOFTWARE;
         end
      end
      if (cause != CZ_NONE) begin
         n.st = ST_HOLD;
         n.core_rst = 1'b1;
         n.por_like = (s.por_like && s.st != ST_RUN) || cause == CZ_BROWNOUT;
         // Only the flag of this cause changes
         case (cause)
            CZ_BROWNOUT: begin
               n.rst_ctrl[B_BROWNOUT] = 1'b1;
            end
            CZ_EXTERNAL: begin
               n.rst_ctrl[B_EXTERNAL] = 1'b1;
            end
            CZ_MISMATCH: begin
               n.rst_ctrl[B_MISMATCH] = 1'b1;
            end
            CZ_TRAP: begin
               n.rst_ctrl[B_TRAP_CONFLICT] = 1'b1;
            end
            CZ_ILLEGAL: begin
               n.rst_ctrl[B_ILLEGAL_OP] = 1'b1;
            end
            CZ_WATCHDOG: begin
               n.rst_ctrl[B_WATCHDOG] = 1'b1;
            end
            default: begin
               n.rst_ctrl[B_SOFTWARE] = 1'b1;
            end
         endcase
         // Default values restored; mismatch keeps the rest
         if (cause != CZ_MISMATCH) begin
            n.stack_err = 1'b0;
            n.trap_pend = 1'b0;
            n.mode = MD_RUN;
         end
      end else begin
         case (s.st)
            ST_HOLD: begin
               n.tm_start = 1'b1;
               if (s.por_like) begin
                  n.st = ST_STUP;
                  n.tm_load = s.s2[2] ? REG_SETTLE_CYC : POWERUP_CYC;
               end else begin
                  n.st = ST_OSC;
                  n.tm_load = OSC_START_CYC;
               end
            end
            ST_STUP: begin
               if (tm_fin) begin
                  n.tm_start = 1'b1;
                  if (s.s2[2] && !s.rst_ctrl[B_REG_STANDBY]) begin
                     n.st = ST_REGX;
                     n.tm_load = REG_EXTRA_CYC;
                  end else begin
                     n.st = ST_OSC;
                     n.tm_load = OSC_START_CYC;
                  end
               end
            end
            ST_REGX: begin
               if (tm_fin) begin
                  n.tm_start = 1'b1;
                  n.st = ST_OSC;
                  n.tm_load = OSC_START_CYC;
               end
            end
            ST_OSC: begin
               if (tm_fin) begin
                  if (pll_en) begin
                     n.tm_start = 1'b1;
                     n.st = ST_PLL;
                     n.tm_load = PLL_LOCK_CYC;
                  end else begin
                     rel = 1'b1;
                  end
               end
            end
            ST_PLL: begin
               rel = tm_fin;
            end
            default: begin
               if (s.mode != MD_RUN) begin
                  // Wake changes only the wake or watchdog flag of the reset control register
                  if (wake_int || wdt_timeout) begin
                     wake_go = 1'b1;
                     n.mode = MD_RUN;
                     n.pc_load = 1'b1;
                     if (wdt_timeout || int_prio <= cpu_prio) begin
                        n.pc_val = cur_pc + PC_INC;
                     end else begin
                        n.pc_val = int_vec;
                     end
                     if (wdt_timeout) begin
                        n.rst_ctrl[B_WATCHDOG] = 1'b1;
                     end else begin
                        n.rst_ctrl[B_WAKE_INT] = 1'b1;
                     end
                  end
               end else begin
                  if (stk) begin
                     stk_go = 1'b1;
                     n.stack_err = 1'b1;
                     n.trap_pend = 1'b1;
                     n.soft_trap = 1'b1;
                     n.pc_load = 1'b1;
                     n.pc_val = STACK_VEC;
                  end else if (trap_event) begin
                     n.trap_pend = 1'b1;
                  end else if (trap_clear) begin
                     n.trap_pend = 1'b0;
                  end
                  if (sleep_req) begin
                     n.mode = MD_SLEEP;
                     n.rst_ctrl[B_SLEEP] = 1'b1;
                  end else if (idle_req) begin
                     n.mode = MD_IDLE;
                     n.rst_ctrl[B_IDLE] = 1'b1;
                  end
               end
            end
         endcase
         if (rel) begin
            n.st = ST_RUN;
            n.core_rst = 1'b0;
            n.por_like = 1'b0;
            n.pc_load = 1'b1;
            n.pc_val = PC_RESET;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s <= '0;
         // Pin syncs keep sampling so the first start-up sees settled levels
         s.s1 <= n.s1;
         s.s2 <= n.s2;
         s.st <= ST_HOLD;
         s.por_like <= 1'b1;
         s.core_rst <= 1'b1;
         s.rst_ctrl <= RESET_CTRL_RST;
         s.hreadyout <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign hrdata = s.hrdata;
   assign hreadyout = s.hreadyout;
   assign hresp = 1'b0;
   assign core_rst = s.core_rst;
   assign pc_load = s.pc_load;
   assign pc_value = s.pc_val;
   assign soft_trap = s.soft_trap;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   sequence s_enter_stup;
      s.st == ST_HOLD ##1 s.st == ST_STUP;
   endsequence

   sequence s_release;
      s.core_rst ##1 !s.core_rst;
   endsequence

   chk_wake_next: assert property (wake_go && (wdt_timeout || int_prio <= cpu_prio)
      |=> s.pc_load && s.pc_val == $past(cur_pc) + PC_INC)
      else $error("wake did not resume at next instruction");
   chk_wake_vector: assert property (wake_go && !wdt_timeout && int_prio > cpu_prio
      |=> s.pc_load && s.pc_val == $past(int_vec))
      else $error("wake did not take interrupt vector");
   chk_illegal_reset: assert property (cause == CZ_ILLEGAL
      |=> s.core_rst && s.rst_ctrl[B_ILLEGAL_OP] && s.st == ST_HOLD)
      else $error("illegal operation did not reset");
   chk_mismatch_keep: assert property (cause == CZ_MISMATCH
      |=> s.core_rst && s.rst_ctrl[B_MISMATCH] && s.stack_err == $past(s.stack_err))
      else $error("mismatch reset wrong");
   chk_trap_conflict: assert property (cause == CZ_TRAP
      |=> s.core_rst && s.rst_ctrl[B_TRAP_CONFLICT] && !s.trap_pend)
      else $error("trap conflict did not reset");
   chk_stack_trap: assert property (stk_go
      |=> s.soft_trap && s.pc_val == STACK_VEC && !s.core_rst ##1 !s.soft_trap)
      else $error("stack error trap wrong");
   chk_stack_shared: assert property (stk_go |=> s.stack_err && s.trap_pend)
      else $error("stack error flag not set");
   chk_brown_hold: assert property (brown [*2] |=> s.core_rst && s.st == ST_HOLD)
      else $error("brown-out did not hold reset");
   chk_startup_sel: assert property (s_enter_stup
      |-> s.tm_load == ($past(s.s2[2]) ? REG_SETTLE_CYC : POWERUP_CYC))
      else $error("start-up interval wrong");
   chk_regx_added: assert property (s.st == ST_STUP && tm_fin && cause == CZ_NONE
      && s.s2[2] && !s.rst_ctrl[B_REG_STANDBY] |=> s.st == ST_REGX && s.tm_start)
      else $error("extra regulator delay missing");
   chk_pll_step: assert property (s.st == ST_OSC && tm_fin && cause == CZ_NONE && pll_en
      |=> s.st == ST_PLL && s.core_rst)
      else $error("pll delay missing");
   chk_master_clear_pin_reset: assert property (master_clear_pin && !brown
      |=> s.core_rst && s.rst_ctrl[B_EXTERNAL])
      else $error("master clear did not reset");
   chk_release_pc: assert property (s_release |-> s.pc_load && s.pc_val == PC_RESET)
      else $error("release did not load zero");
endmodule
`default_nettype wire
